// *** scprr_host.sv ***
// Host model driving the parallel register strobes of the bank
module scprr_host (
  input wire logic clock,
  output logic wr_en,
  output logic rd_en,
  output logic [15:0] addr,
  output logic [7:0] wr_data,
  input wire logic [7:0] rd_data,
  input wire logic rd_valid
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    wr_en = 1'b0;
    rd_en = 1'b0;
    addr = 16'h0000;
    wr_data = 8'h00;
  end
  // Request held over one sampling edge, then released to inverted values
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(negedge clock);
    addr = a;
    wr_data = d;
    wr_en = 1'b1;
    @(negedge clock);
    wr_en = 1'b0;
    addr = ~a;
    wr_data = ~d;
  endtask
  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    int n;
    @(negedge clock);
    addr = a;
    rd_en = 1'b1;
    @(negedge clock);
    rd_en = 1'b0;
    addr = ~a;
    for (n = 0; n < 3 && rd_valid !== 1'b1; n++) @(negedge clock);
    d = (rd_valid === 1'b1) ? rd_data : 8'hxx;
  endtask
endmodule // scprr_host

// *** scprr_pkg.sv ***
// Package with register map constants and control bundles for the config bank
package scprr_pkg;
  localparam logic [15:0] SCPRR_ADDR_SERIAL_CFG = 16'h0000;
  localparam logic [15:0] SCPRR_ADDR_RSVD_ONE = 16'h0001;
  localparam logic [15:0] SCPRR_ADDR_PART_IDENTIFIER_HIGH_LO = 16'h0002;
  localparam logic [15:0] SCPRR_ADDR_PART_IDENTIFIER_HIGH_HI = 16'h0003;
  localparam logic [15:0] SCPRR_ADDR_READBACK_OPT = 16'h0004;
  localparam logic [15:0] SCPRR_ADDR_SW_UPDATE = 16'h0005;
  localparam logic [15:0] SCPRR_ADDR_POWER_CTRL = 16'h0010;
  localparam logic [15:0] SCPRR_ADDR_RSVD_ELEVEN = 16'h0011;
  localparam logic [15:0] SCPRR_ADDR_PULSE_RST = 16'h0012;
  localparam logic [15:0] SCPRR_ADDR_LEVEL_RST = 16'h0013;

  localparam int SCPRR_CFG_SDO_BIT = 0;
  localparam int SCPRR_CFG_LSB_BIT = 1;
  localparam int SCPRR_CFG_SOFT_RST_BIT = 2;
  localparam int SCPRR_CFG_LONG_BIT = 3;
  localparam int SCPRR_RDBK_BUF_BIT = 0;
  localparam int SCPRR_UPDATE_BIT = 0;

  localparam int SCPRR_PWR_DIFF_PD_BIT = 7;
  localparam int SCPRR_PWR_CMOS_EN_BIT = 6;
  localparam int SCPRR_PWR_DOUBLER_BIT = 5;
  localparam int SCPRR_PWR_SYSPLL_PD_BIT = 4;
  localparam int SCPRR_PWR_REFERENCE_INPUT_A_PD_BIT = 3;
  localparam int SCPRR_PWR_REFERENCE_INPUT_B_PD_BIT = 2;
  localparam int SCPRR_PWR_FULL_POWER_DOWN_BIT = 1;
  localparam int SCPRR_PWR_DIG_PD_BIT = 0;

  localparam int SCPRR_PRST_HISTORY_BIT = 7;
  localparam int SCPRR_PRST_IRQ_BIT = 5;
  localparam logic [7:0] SCPRR_PRST_MASK = 8'hbf;

  localparam int SCPRR_LRST_FUND_OFF_BIT = 7;
  localparam logic [7:0] SCPRR_LRST_MASK = 8'h8f;

  // Long instruction bit set and mirrored into the upper nibble
  localparam logic [3:0] SCPRR_CFG_LOW_RESET = 4'h8;
  localparam logic [7:0] SCPRR_RDBK_RESET = 8'h00;
  localparam logic [7:0] SCPRR_LRST_RESET = 8'h00;
  // Values are arbitrary
  localparam logic [7:0] SCPRR_PART_IDENTIFIER_HIGH_LO_VAL = 8'h5a;
  localparam logic [7:0] SCPRR_PART_IDENTIFIER_HIGH_HI_VAL = 8'ha5;

  typedef struct packed {
    logic diff_driver_pd;
    logic cmos_driver_en;
    logic doubler_pwr_up;
    logic sys_pll_pd;
    logic ref_a_pd;
    logic ref_b_pd;
    logic full_power_down;
    logic digital_power_down;
  } scprr_power_t;

  typedef struct packed {
    logic history_clear;
    logic irq_clear;
    logic fine_phase_detector_rst;
    logic coarse_phase_detector_rst;
    logic loop_filter_rst;
    logic comb_integrator_rst;
    logic synth_core_rst;
  } scprr_pulse_t;

  typedef struct packed {
    logic fundamental_output_off;
    logic fb_prescaler_rst;
    logic in_prescaler_rst;
    logic fb_divider_rst;
    logic in_divider_rst;
  } scprr_level_t;
endpackage : scprr_pkg

// *** scprr_regs.sv ***
// Serial configuration, power-down and reset register bank
// Functional notes
// - Upper config nibble mirrors the lower nibble
// - Long instruction bit reads one, read-only
// - Soft reset restores all but config register
// - Soft reset keeps hard-reset startup pin values
// - Soft reset bit holds until written zero
// - Bit order: one LSB first, zero MSB
// - Return to MSB first waits for update
// - Readback select picks pending or active values
// - Update bit acts like update pin
// - Differential driver off, CMOS driver on bits
// - Doubler power-up bit, also enabled elsewhere
// - PLL, reference A, reference B power-downs
// - Full power-down equals power-down pin
// - Digital power-down gates digital clock
// - Power register defaults from startup pins
// - Pulse bits clear monitor and interrupt
// - Low pulse bits reset loop sub-blocks
// - Level bit switches fundamental output off
// - Prescaler resets held until cleared
// - Divider reset bits for integer dividers
// - Buffered registers activate on update
module scprr_regs
  import scprr_pkg::*;
(
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [15:0] addr,
  input wire logic [7:0] wr_data,
  output logic [7:0] rd_data,
  output logic rd_valid,
  input wire logic io_update_pin,
  input wire logic power_down_pin,
  input wire logic [3:0] startup_config_pins,
  output logic lsb_first,
  output logic serial_data_out_pin_en,
  output logic soft_reset_active,
  output logic [3:0] startup_latched,
  output scprr_power_t power_ctrl,
  output logic digital_clock_gate,
  output logic system_clock_off,
  output scprr_pulse_t pulse_resets,
  output scprr_level_t level_resets
);
  logic [3:0] cfg_low_reg;
  logic lsb_active_reg;
  logic [7:0] rdbk_reg;
  logic [7:0] pwr_buf_reg;
  logic [7:0] pwr_act_reg;
  logic [7:0] lrst_reg;
  logic [7:0] prst_reg;
  logic startup_take_reg;
  logic [3:0] startup_reg;
  logic soft_rst;
  logic io_update;
  logic [7:0] cfg_full;
  logic [7:0] pwr_default;
  logic [7:0] rd_next;

  assign soft_rst = cfg_low_reg[SCPRR_CFG_SOFT_RST_BIT];
  assign io_update = io_update_pin ||
    (wr_en && addr == SCPRR_ADDR_SW_UPDATE && wr_data[SCPRR_UPDATE_BIT]);
  assign cfg_full = {cfg_low_reg[0], cfg_low_reg[1], cfg_low_reg[2], cfg_low_reg[3],
    cfg_low_reg};
  assign pwr_default = {4'h0, startup_reg};

  // Startup pins caught once after hard reset
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      startup_take_reg <= 1'b1;
      startup_reg <= 4'h0;
    end else if (startup_take_reg) begin
      startup_take_reg <= 1'b0;
      startup_reg <= startup_config_pins;
    end
  end

  // Long instruction forced, soft reset held
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      cfg_low_reg <= SCPRR_CFG_LOW_RESET;
    end else if (wr_en && addr == SCPRR_ADDR_SERIAL_CFG) begin
      // Only a write or hard reset clears soft reset
      cfg_low_reg <= {1'b1, wr_data[2:0]};
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      lsb_active_reg <= 1'b0;
    end else if (cfg_low_reg[SCPRR_CFG_LSB_BIT]) begin
      lsb_active_reg <= 1'b1;
    end else if (io_update) begin
      lsb_active_reg <= 1'b0;
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      rdbk_reg <= SCPRR_RDBK_RESET;
      lrst_reg <= SCPRR_LRST_RESET;
    end else if (soft_rst) begin
      rdbk_reg <= SCPRR_RDBK_RESET;
      lrst_reg <= SCPRR_LRST_RESET;
    end else if (wr_en) begin
      if (addr == SCPRR_ADDR_READBACK_OPT) begin
        rdbk_reg <= {7'h00, wr_data[SCPRR_RDBK_BUF_BIT]};
      end else if (addr == SCPRR_ADDR_LEVEL_RST) begin
        lrst_reg <= wr_data & SCPRR_LRST_MASK;
      end
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      pwr_buf_reg <= 8'h00;
      pwr_act_reg <= 8'h00;
    end else if (startup_take_reg || soft_rst) begin
      pwr_buf_reg <= {4'h0, (startup_take_reg ? startup_config_pins : startup_reg)};
      pwr_act_reg <= {4'h0, (startup_take_reg ? startup_config_pins : startup_reg)};
    end else begin
      if (wr_en && addr == SCPRR_ADDR_POWER_CTRL) begin
        pwr_buf_reg <= wr_data;
      end
      if (io_update) begin
        pwr_act_reg <= (wr_en && addr == SCPRR_ADDR_POWER_CTRL) ? wr_data : pwr_buf_reg;
      end
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      prst_reg <= 8'h00;
    end else if (wr_en && addr == SCPRR_ADDR_PULSE_RST && !soft_rst) begin
      prst_reg <= wr_data & SCPRR_PRST_MASK;
    end else begin
      prst_reg <= 8'h00;
    end
  end

  always_comb begin
    rd_next = 8'h00;
    if (addr == SCPRR_ADDR_SERIAL_CFG) begin
      rd_next = cfg_full;
    end else if (addr == SCPRR_ADDR_PART_IDENTIFIER_HIGH_LO) begin
      rd_next = SCPRR_PART_IDENTIFIER_HIGH_LO_VAL;
    end else if (addr == SCPRR_ADDR_PART_IDENTIFIER_HIGH_HI) begin
      rd_next = SCPRR_PART_IDENTIFIER_HIGH_HI_VAL;
    end else if (addr == SCPRR_ADDR_READBACK_OPT) begin
      rd_next = rdbk_reg;
    end else if (addr == SCPRR_ADDR_POWER_CTRL) begin
      rd_next = rdbk_reg[SCPRR_RDBK_BUF_BIT] ? pwr_buf_reg : pwr_act_reg;
    end else if (addr == SCPRR_ADDR_LEVEL_RST) begin
      rd_next = lrst_reg;
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      rd_data <= 8'h00;
      rd_valid <= 1'b0;
    end else begin
      rd_data <= rd_en ? rd_next : 8'h00;
      rd_valid <= rd_en;
    end
  end

  // Registered control outputs
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      lsb_first <= 1'b0;
      serial_data_out_pin_en <= 1'b0;
      soft_reset_active <= 1'b0;
      startup_latched <= 4'h0;
      power_ctrl <= '0;
      digital_clock_gate <= 1'b0;
      system_clock_off <= 1'b0;
      pulse_resets <= '0;
      level_resets <= '0;
    end else begin
      lsb_first <= lsb_active_reg;
      serial_data_out_pin_en <= cfg_low_reg[SCPRR_CFG_SDO_BIT];
      soft_reset_active <= soft_rst;
      startup_latched <= startup_reg;
      power_ctrl.diff_driver_pd <= pwr_act_reg[SCPRR_PWR_DIFF_PD_BIT];
      power_ctrl.cmos_driver_en <= pwr_act_reg[SCPRR_PWR_CMOS_EN_BIT];
      power_ctrl.doubler_pwr_up <= pwr_act_reg[SCPRR_PWR_DOUBLER_BIT];
      power_ctrl.sys_pll_pd <= pwr_act_reg[SCPRR_PWR_SYSPLL_PD_BIT];
      power_ctrl.ref_a_pd <= pwr_act_reg[SCPRR_PWR_REFERENCE_INPUT_A_PD_BIT];
      power_ctrl.ref_b_pd <= pwr_act_reg[SCPRR_PWR_REFERENCE_INPUT_B_PD_BIT];
      power_ctrl.full_power_down <= pwr_act_reg[SCPRR_PWR_FULL_POWER_DOWN_BIT] || power_down_pin;
      system_clock_off <= pwr_act_reg[SCPRR_PWR_FULL_POWER_DOWN_BIT] || power_down_pin;
      power_ctrl.digital_power_down <= pwr_act_reg[SCPRR_PWR_DIG_PD_BIT];
      digital_clock_gate <= pwr_act_reg[SCPRR_PWR_DIG_PD_BIT] ||
        pwr_act_reg[SCPRR_PWR_FULL_POWER_DOWN_BIT] || power_down_pin;
      pulse_resets.history_clear <= prst_reg[SCPRR_PRST_HISTORY_BIT];
      pulse_resets.irq_clear <= prst_reg[SCPRR_PRST_IRQ_BIT];
      {pulse_resets.fine_phase_detector_rst, pulse_resets.coarse_phase_detector_rst,
        pulse_resets.loop_filter_rst, pulse_resets.comb_integrator_rst,
        pulse_resets.synth_core_rst} <= prst_reg[4:0];
      level_resets.fundamental_output_off <= lrst_reg[SCPRR_LRST_FUND_OFF_BIT];
      {level_resets.fb_prescaler_rst, level_resets.in_prescaler_rst,
        level_resets.fb_divider_rst, level_resets.in_divider_rst} <= lrst_reg[3:0];
    end
  end

  AST_CFG_MIRROR: assert property (@(posedge clock) disable iff (sys_rst)
    rd_en && addr == SCPRR_ADDR_SERIAL_CFG |=> rd_data[7:4] == {rd_data[0], rd_data[1],
    rd_data[2], rd_data[3]})
    else $error("config readback not mirrored");
  AST_LONG_BIT: assert property (@(posedge clock) disable iff (sys_rst)
    cfg_low_reg[SCPRR_CFG_LONG_BIT] == 1'b1)
    else $error("long instruction bit cleared");
  AST_SOFT_CLEAR: assert property (@(posedge clock) disable iff (sys_rst)
    soft_rst ##1 soft_rst |-> lrst_reg == SCPRR_LRST_RESET && rdbk_reg == SCPRR_RDBK_RESET)
    else $error("soft reset left register set");
  // Startup value stable under soft reset
  AST_STARTUP_KEEP: assert property (@(posedge clock) disable iff (sys_rst)
    !startup_take_reg |=> $stable(startup_reg))
    else $error("startup value changed");
  AST_SOFT_HOLD: assert property (@(posedge clock) disable iff (sys_rst)
    soft_rst && !(wr_en && addr == SCPRR_ADDR_SERIAL_CFG) |=> soft_rst)
    else $error("soft reset self cleared");
  sequence scprr_msb_req_s;
    !cfg_low_reg[SCPRR_CFG_LSB_BIT] && lsb_active_reg && !io_update;
  endsequence
  AST_MSB_WAIT: assert property (@(posedge clock) disable iff (sys_rst)
    scprr_msb_req_s |=> lsb_active_reg)
    else $error("MSB first took effect early");
  AST_UPDATE_MOVE: assert property (@(posedge clock) disable iff (sys_rst)
    io_update && !startup_take_reg && !soft_rst &&
    !(wr_en && addr == SCPRR_ADDR_POWER_CTRL) |=> pwr_act_reg == $past(pwr_buf_reg))
    else $error("update did not copy buffer");
  AST_BUF_HOLD: assert property (@(posedge clock) disable iff (sys_rst)
    !io_update && !startup_take_reg && !soft_rst |=> $stable(pwr_act_reg))
    else $error("active value changed without update");
  AST_PULSE_CLEAR: assert property (@(posedge clock) disable iff (sys_rst)
    prst_reg != 8'h00 && !(wr_en && addr == SCPRR_ADDR_PULSE_RST) |=>
    prst_reg == 8'h00 ##1 pulse_resets == '0)
    else $error("pulse reset stuck");
  AST_PIN_PD: assert property (@(posedge clock) disable iff (sys_rst)
    power_down_pin |=> power_ctrl.full_power_down && system_clock_off)
    else $error("power-down pin ignored");
endmodule // scprr_regs

// *** serial_config_power_reset_regs_tb.sv ***
// Self-checking bench for the configuration, power and reset bank
module serial_config_power_reset_regs_tb;
  import scprr_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock, sys_rst, wr_en, rd_en, rd_valid, io_update_pin, power_down_pin;
  logic lsb_first, serial_data_out_pin_en, soft_reset_active;
  logic digital_clock_gate, system_clock_off;
  logic [15:0] addr;
  logic [7:0] wr_data, rd_data;
  logic [3:0] startup_config_pins, startup_latched;
  scprr_power_t power_ctrl;
  scprr_pulse_t pulse_resets;
  scprr_level_t level_resets;
  int failures, total_checks;

  scprr_regs i_scprr_regs (.clock(clock), .sys_rst(sys_rst), .wr_en(wr_en), .rd_en(rd_en),
    .addr(addr), .wr_data(wr_data), .rd_data(rd_data), .rd_valid(rd_valid),
    .io_update_pin(io_update_pin), .power_down_pin(power_down_pin),
    .startup_config_pins(startup_config_pins), .lsb_first(lsb_first),
    .serial_data_out_pin_en(serial_data_out_pin_en), .soft_reset_active(soft_reset_active),
    .startup_latched(startup_latched), .power_ctrl(power_ctrl),
    .digital_clock_gate(digital_clock_gate), .system_clock_off(system_clock_off),
    .pulse_resets(pulse_resets), .level_resets(level_resets));
  scprr_host i_scprr_host (.clock(clock), .wr_en(wr_en), .rd_en(rd_en), .addr(addr),
    .wr_data(wr_data), .rd_data(rd_data), .rd_valid(rd_valid));

  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      $display("unexpected at %0t ns: got %h expected %h", $time, got, exp);
      failures++;
    end
  endtask
  task automatic rdchk(input logic [15:0] a, input logic [7:0] exp);
    logic [7:0] d;
    i_scprr_host.rd(a, d);
    chk(d, exp);
  endtask
  task automatic wait_cyc(input int n);
    repeat (n) @(negedge clock);
  endtask
  task automatic give_verdict;
    if (failures == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic test_reset_map;
    rdchk(SCPRR_ADDR_SERIAL_CFG, 8'h18); // mirrored default
    rdchk(SCPRR_ADDR_POWER_CTRL, 8'h04); // default from pins
    chk({4'h0, startup_latched}, 8'h04); // pins latched
    rdchk(SCPRR_ADDR_RSVD_ONE, 8'h00);
    rdchk(SCPRR_ADDR_RSVD_ELEVEN, 8'h00);
    rdchk(16'h0020, 8'h00);
    i_scprr_host.wr(SCPRR_ADDR_PART_IDENTIFIER_HIGH_LO, 8'h00);
    rdchk(SCPRR_ADDR_PART_IDENTIFIER_HIGH_LO, SCPRR_PART_IDENTIFIER_HIGH_LO_VAL);
    rdchk(SCPRR_ADDR_PART_IDENTIFIER_HIGH_HI, SCPRR_PART_IDENTIFIER_HIGH_HI_VAL);
  endtask

  task automatic test_serial_cfg;
    i_scprr_host.wr(SCPRR_ADDR_SERIAL_CFG, 8'h03);
    wait_cyc(3);
    chk({7'h0, lsb_first}, 8'h01); // LSB first at once
    chk({7'h0, serial_data_out_pin_en}, 8'h01); // four-wire mode
    rdchk(SCPRR_ADDR_SERIAL_CFG, 8'hdb); // mirror of low nibble
    i_scprr_host.wr(SCPRR_ADDR_SERIAL_CFG, 8'h01);
    wait_cyc(3);
    chk({7'h0, lsb_first}, 8'h01); // waits for update
    rdchk(SCPRR_ADDR_SERIAL_CFG, 8'h99); // long bit stays set
    i_scprr_host.wr(SCPRR_ADDR_SW_UPDATE, 8'h01);
    wait_cyc(3);
    chk({7'h0, lsb_first}, 8'h00); // MSB first after update
  endtask

  task automatic test_power;
    int i;
    i_scprr_host.wr(SCPRR_ADDR_POWER_CTRL, 8'h80);
    wait_cyc(3);
    chk(power_ctrl, 8'h04); // held in buffer
    rdchk(SCPRR_ADDR_POWER_CTRL, 8'h04); // active value read
    i_scprr_host.wr(SCPRR_ADDR_READBACK_OPT, 8'h01);
    rdchk(SCPRR_ADDR_POWER_CTRL, 8'h80); // pending value read
    rdchk(SCPRR_ADDR_READBACK_OPT, 8'h01);
    @(negedge clock);
    io_update_pin = 1'b1;
    @(negedge clock);
    io_update_pin = 1'b0;
    wait_cyc(3);
    chk(power_ctrl, 8'h80); // active after pin update
    i_scprr_host.wr(SCPRR_ADDR_READBACK_OPT, 8'h00);
    for (i = 0; i < 8; i++) begin
      i_scprr_host.wr(SCPRR_ADDR_POWER_CTRL, 8'(8'h01 << i));
      i_scprr_host.wr(SCPRR_ADDR_SW_UPDATE, 8'h01); // software update
      wait_cyc(3);
      chk(power_ctrl, 8'(8'h01 << i)); // each control bit
      chk({6'h0, system_clock_off, digital_clock_gate}, {6'h0, i == 1, i <= 1});
    end
    @(negedge clock);
    power_down_pin = 1'b1;
    wait_cyc(3);
    chk({6'h0, system_clock_off, digital_clock_gate}, 8'h03); // pin powers down
    power_down_pin = 1'b0;
    wait_cyc(3);
    chk({6'h0, system_clock_off, digital_clock_gate}, 8'h00);
  endtask

  task automatic test_pulses;
    int i, hits;
    logic [7:0] b;
    logic [6:0] seen;
    for (i = 0; i < 9; i++) begin
      b = (i == 8) ? 8'h1f : 8'(8'h01 << i);
      i_scprr_host.wr(SCPRR_ADDR_PULSE_RST, b);
      hits = 0;
      seen = 7'h00;
      repeat (5) begin
        @(negedge clock);
        if (pulse_resets !== 7'h00) begin
          hits++;
          seen = pulse_resets;
        end
      end
      chk({1'b0, seen}, {1'b0, b[7], b[5:0]}); // bit mapping
      chk(8'(hits), {7'h0, ~b[6]}); // single pulse
      rdchk(SCPRR_ADDR_PULSE_RST, 8'h00); // reads back zero
    end
  endtask

  task automatic test_levels;
    i_scprr_host.wr(SCPRR_ADDR_LEVEL_RST, 8'hff);
    wait_cyc(3);
    chk({3'h0, level_resets}, 8'h1f); // levels set
    rdchk(SCPRR_ADDR_LEVEL_RST, 8'h8f); // readback of levels
    wait_cyc(8);
    chk({3'h0, level_resets}, 8'h1f); // held until cleared
  endtask

  task automatic test_soft_reset;
    startup_config_pins = 4'ha;
    i_scprr_host.wr(SCPRR_ADDR_SERIAL_CFG, 8'h04);
    wait_cyc(3);
    chk({7'h0, soft_reset_active}, 8'h01); // soft reset taken
    chk(power_ctrl, 8'h04); // back to latched pins
    chk({3'h0, level_resets}, 8'h00); // levels cleared
    chk({4'h0, startup_latched}, 8'h04); // no resampling
    chk({7'h0, serial_data_out_pin_en}, 8'h00); // three-wire mode
    rdchk(SCPRR_ADDR_SERIAL_CFG, 8'h3c); // config kept
    i_scprr_host.wr(SCPRR_ADDR_LEVEL_RST, 8'h8f);
    i_scprr_host.wr(SCPRR_ADDR_READBACK_OPT, 8'h01);
    i_scprr_host.wr(SCPRR_ADDR_PULSE_RST, 8'h01);
    wait_cyc(8);
    chk({3'h0, level_resets}, 8'h00); // writes held off
    chk({1'b0, pulse_resets}, 8'h00); // pulse outputs idle after the wait
    rdchk(SCPRR_ADDR_READBACK_OPT, 8'h00); // readback select held off
    chk({7'h0, soft_reset_active}, 8'h01); // not self-clearing
    i_scprr_host.wr(SCPRR_ADDR_SERIAL_CFG, 8'h01);
    wait_cyc(3);
    chk({7'h0, soft_reset_active}, 8'h00); // cleared by host
    rdchk(SCPRR_ADDR_POWER_CTRL, 8'h04); // default restored
  endtask

  initial begin
    failures = 0;
    total_checks = 0;
    sys_rst = 1'b1;
    io_update_pin = 1'b0;
    power_down_pin = 1'b0;
    startup_config_pins = 4'h4;
    wait_cyc(8);
    sys_rst = 1'b0;
    wait_cyc(2);
    test_reset_map();
    test_serial_cfg();
    test_power();
    test_pulses();
    test_levels();
    test_soft_reset();
    give_verdict();
  end

  initial begin
    repeat (20000) @(posedge clock);
    failures++;
    give_verdict();
  end
endmodule // serial_config_power_reset_regs_tb
